// ---- rtl/rca_pkg.sv ----
// package: constants and state types of the release countdown block
package rca_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL  = 8'h00;
  localparam logic [7:0] OFF_DELAY = 8'h04;
  localparam logic [7:0] OFF_CUT   = 8'h08;
  localparam logic [7:0] OFF_THR   = 8'h0c;
  localparam logic [7:0] OFF_QRY   = 8'h10;
  localparam logic [7:0] OFF_STAT  = 8'h14;
  // abort styles
  localparam logic [1:0] ABT_FULL   = 2'h0;
  localparam logic [1:0] ABT_FLOOR  = 2'h1;
  localparam logic [1:0] ABT_EXTEND = 2'h2;
  localparam logic [1:0] ABT_FREEZE = 2'h3;
  // timing
  localparam int         CLK_NS     = 20;
  localparam int         TICK_NS    = 1000000000;
  localparam int         TICK_CYC   = TICK_NS / CLK_NS;
  localparam logic [16:0] FLOOR_S   = 17'h0000a;
  localparam logic [16:0] EXTRA_S   = 17'h0005a;
  localparam logic [7:0]  CUT_MAX   = 8'hb4;
  localparam logic [13:0] SEC_PER_MIN = 14'h003c;
  // thresholds in 0.1 %/ft steps
  localparam logic [7:0] PRE_MIN   = 8'h07;
  localparam logic [7:0] ALM_MIN   = 8'h09;
  localparam logic [7:0] PRE_RST   = 8'h0f;
  localparam logic [7:0] ALM_RST   = 8'h14;
  localparam logic [15:0] DELAY_RST = 16'h001e;
  localparam logic [1:0] RESP_OK   = 2'h0;
  localparam logic [1:0] RESP_ERR  = 2'h2;

  typedef enum logic [2:0] {
    TH_IDLE = 3'b000,
    TH_INIT = 3'b001,
    TH_SIL  = 3'b010,
    TH_OFF  = 3'b011,
    TH_CYC  = 3'b100
  } rca_th_t;

  // night in the top byte, pre-alarm in the low byte, as software writes them
  typedef struct packed {
    logic [7:0] ngt;
    logic [7:0] alm;
    logic [7:0] pre;
  } rca_thr_t;

  typedef struct packed {
    logic [2:0]  abt_sy;
    logic [2:0]  ngt_sy;
    logic [3:0]  ht_s1;
    logic [3:0]  ht_s2;
    logic [3:0]  ht_s3;
    logic        abt;
    logic        abt_prev;
    logic        ngt;
    logic [3:0]  ht;
    logic [3:0]  ht_prev;
    logic [25:0] div;
    logic        tick;
    logic [16:0] cd;
    logic        run;
    logic        released;
    rca_th_t     th;
    logic [13:0] tcnt;
    logic        cyc_out;
    logic [1:0]  style;
    logic        therm_en;
    logic [15:0] delay;
    logic [7:0]  initial_cutoff_interval;
    logic [7:0]  cyclical_cutoff_interval;
    logic        ini_min;
    logic        cyc_min;
    rca_thr_t    thr;
    rca_thr_t    pend;
    logic        query;
    logic        edit_open;
    logic        reject;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } rca_state_t;
endpackage

// ---- rtl/rca_top.sv ----
// release countdown with abort styles, thermal cycling and threshold checks
// Function
// - full-reset style: abort activation reloads the full delay
// - full-reset style: abort release restarts the full countdown
// - full-reset style: each reactivation with time left reloads full delay
// - countdown is cleared only by system reset, never by abort
// - floor style: abort keeps counting but stops at 10 seconds
// - floor style: abort release resumes counting from 10 seconds
// - floor style: abort with under 10 seconds left restores 10 seconds
// - extended style: abort reloads full delay plus 90 seconds
// - extended style: abort release counts down from delay plus 90
// - extended style: reactivation with time left reloads delay plus 90
// - freeze style: abort halts countdown at remaining value
// - freeze style: abort release continues from held value
// - freeze style: every reactivation freezes countdown again
// - first heat alarm turns outputs on for initial cutoff interval
// - outputs switch off when the initial interval expires
// - heat still in alarm at expiry re-runs initial interval
// - no heat alarm at initial expiry leaves outputs off
// - each new heat exceedance while off runs cyclical interval
// - both intervals take 0 to 180, seconds or minutes per interval
// - low smoke entry raises query; accept clamps, decline keeps edit
// - pre-alarm threshold must be strictly below alarm threshold
// - night threshold at most day threshold, chosen by time of day
//
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module rca_top #(
  parameter int TICK_CYCLES = rca_pkg::TICK_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        abort_in,
  input  wire logic        night_in,
  input  wire logic [3:0]  heat_in,
  output logic             release_out,
  output logic             cycle_out,
  output logic             countdown_run,
  output logic [7:0]       alarm_thr_active,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  rca_pkg::rca_state_t st_q;
  rca_pkg::rca_state_t st_d;
  logic        wr_fire;
  logic        rise;
  logic        ht_new;
  logic        t_exp;
  logic [31:0] wmask;
  logic [31:0] wmrg;
  logic [7:0]  ra;
  logic [13:0] ld_ini;
  logic [13:0] ld_cyc;

  // ----------------------------------------
  // bus handshakes
  // ----------------------------------------
  // ready drops once the half is held, so a stalled response blocks more
  assign s_axi_awready = !st_q.aw_got && !st_q.bvalid;
  assign s_axi_wready  = !st_q.w_got && !st_q.bvalid;
  assign s_axi_arready = !st_q.rvalid;
  assign s_axi_bvalid  = st_q.bvalid;
  assign s_axi_bresp   = st_q.bresp;
  assign s_axi_rvalid  = st_q.rvalid;
  assign s_axi_rdata   = st_q.rdata;
  assign s_axi_rresp   = st_q.rresp;
  assign release_out   = st_q.released;
  assign cycle_out     = st_q.cyc_out;
  assign countdown_run = st_q.run;
  // night set chosen by time-of-day input
  assign alarm_thr_active = st_q.ngt ? st_q.thr.ngt : st_q.thr.alm;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    // three-stage input capture, change taken when stages two and three agree
    st_d.abt_sy = {st_q.abt_sy[1:0], abort_in};
    st_d.ngt_sy = {st_q.ngt_sy[1:0], night_in};
    st_d.ht_s1  = heat_in;
    st_d.ht_s2  = st_q.ht_s1;
    st_d.ht_s3  = st_q.ht_s2;
    if (st_q.abt_sy[1] == st_q.abt_sy[2]) begin
      st_d.abt = st_q.abt_sy[1];
    end
    if (st_q.ngt_sy[1] == st_q.ngt_sy[2]) begin
      st_d.ngt = st_q.ngt_sy[1];
    end
    st_d.ht = (~(st_q.ht_s2 ^ st_q.ht_s3) & st_q.ht_s2)
            | ((st_q.ht_s2 ^ st_q.ht_s3) & st_q.ht);
    st_d.abt_prev = st_q.abt;
    st_d.ht_prev  = st_q.ht;
    rise   = st_q.abt && !st_q.abt_prev;
    ht_new = |(st_q.ht & ~st_q.ht_prev);

    // one-second tick
    st_d.tick = 1'b0;
    if (st_q.div == 26'(TICK_CYCLES - 1)) begin
      st_d.div  = '0;
      st_d.tick = 1'b1;
    end else begin
      st_d.div = st_q.div + 26'h0000001;
    end

    // write channel capture, either order
    if (s_axi_awvalid && s_axi_awready) begin
      st_d.aw_got = 1'b1;
      st_d.awaddr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_d.w_got = 1'b1;
      st_d.wdata = s_axi_wdata;
      st_d.wstrb = s_axi_wstrb;
    end
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end
    wr_fire = st_q.aw_got && st_q.w_got && !st_q.bvalid;
    wmask = {{8{st_q.wstrb[3]}}, {8{st_q.wstrb[2]}},
             {8{st_q.wstrb[1]}}, {8{st_q.wstrb[0]}}};
    wmrg  = st_q.wdata & wmask;

    // countdown, cleared only by reset
    if (st_q.run) begin
      case (st_q.style)
        rca_pkg::ABT_FULL: begin
          if (rise) begin
            st_d.cd = {1'b0, st_q.delay};
          end else if (!st_q.abt && st_q.tick) begin
            st_d.cd = st_q.cd - 17'h00001;
          end
        end
        rca_pkg::ABT_FLOOR: begin
          if (rise && st_q.cd < rca_pkg::FLOOR_S) begin
            st_d.cd = rca_pkg::FLOOR_S;
          end else if (st_q.tick
                       && !(st_q.abt && st_q.cd <= rca_pkg::FLOOR_S)) begin
            st_d.cd = st_q.cd - 17'h00001;
          end
        end
        rca_pkg::ABT_EXTEND: begin
          if (rise) begin
            st_d.cd = {1'b0, st_q.delay} + rca_pkg::EXTRA_S;
          end else if (!st_q.abt && st_q.tick) begin
            st_d.cd = st_q.cd - 17'h00001;
          end
        end
        default: begin
          // held value kept, no reload
          if (!st_q.abt && st_q.tick) begin
            st_d.cd = st_q.cd - 17'h00001;
          end
        end
      endcase
      if (st_q.cd == '0) begin
        st_d.run      = 1'b0;
        st_d.released = 1'b1;
      end
    end

    // thermal cycling sequencer
    ld_ini = st_q.ini_min
           ? 14'(st_q.initial_cutoff_interval * rca_pkg::SEC_PER_MIN)
           : {6'h00, st_q.initial_cutoff_interval};
    ld_cyc = st_q.cyc_min
           ? 14'(st_q.cyclical_cutoff_interval * rca_pkg::SEC_PER_MIN)
           : {6'h00, st_q.cyclical_cutoff_interval};
    t_exp = (st_q.tcnt == '0)
         || (st_q.tick && st_q.tcnt == 14'h0001);
    if (st_q.tick && st_q.tcnt != '0) begin
      st_d.tcnt = st_q.tcnt - 14'h0001;
    end
    case (st_q.th)
      rca_pkg::TH_IDLE: begin
        if (st_q.therm_en && |st_q.ht) begin
          st_d.th      = rca_pkg::TH_INIT;
          st_d.tcnt    = ld_ini;
          st_d.cyc_out = 1'b1;
        end
      end
      rca_pkg::TH_INIT: begin
        if (t_exp) begin
          st_d.th      = rca_pkg::TH_SIL;
          st_d.cyc_out = 1'b0;
        end
      end
      rca_pkg::TH_SIL: begin
        // one-cycle gap shows the drop before any rerun
        if (|st_q.ht) begin
          st_d.th      = rca_pkg::TH_INIT;
          st_d.tcnt    = ld_ini;
          st_d.cyc_out = 1'b1;
        end else begin
          st_d.th = rca_pkg::TH_OFF;
        end
      end
      rca_pkg::TH_OFF: begin
        if (ht_new) begin
          st_d.th      = rca_pkg::TH_CYC;
          st_d.tcnt    = ld_cyc;
          st_d.cyc_out = 1'b1;
        end
      end
      rca_pkg::TH_CYC: begin
        if (t_exp) begin
          st_d.th      = rca_pkg::TH_OFF;
          st_d.cyc_out = 1'b0;
        end
      end
      default: begin
        st_d.th = rca_pkg::TH_IDLE;
      end
    endcase

    // register writes
    if (wr_fire) begin
      st_d.aw_got = 1'b0;
      st_d.w_got  = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp  = rca_pkg::RESP_OK;
      if (st_q.awaddr == rca_pkg::OFF_CTRL) begin
        if (st_q.wstrb[0]) begin
          st_d.style    = st_q.wdata[1:0];
          st_d.therm_en = st_q.wdata[2];
        end
        // start only from idle; later starts cannot clear a count
        if (wmrg[8] && !st_q.run && !st_q.released) begin
          st_d.run = 1'b1;
          st_d.cd  = {1'b0, st_q.delay};
        end
      end else if (st_q.awaddr == rca_pkg::OFF_DELAY) begin
        st_d.delay = (st_q.delay & ~wmask[15:0]) | wmrg[15:0];
      end else if (st_q.awaddr == rca_pkg::OFF_CUT) begin
        if (st_q.wstrb[0]) begin
          st_d.initial_cutoff_interval = (st_q.wdata[7:0] > rca_pkg::CUT_MAX)
                                       ? rca_pkg::CUT_MAX
                                       : st_q.wdata[7:0];
        end
        if (st_q.wstrb[1]) begin
          st_d.cyclical_cutoff_interval = (st_q.wdata[15:8] > rca_pkg::CUT_MAX)
                                        ? rca_pkg::CUT_MAX
                                        : st_q.wdata[15:8];
        end
        if (st_q.wstrb[2]) begin
          st_d.ini_min = st_q.wdata[16];
          st_d.cyc_min = st_q.wdata[17];
        end
      end else if (st_q.awaddr == rca_pkg::OFF_THR) begin
        st_d.pend = st_q.wdata[23:0];
        if (st_q.wdata[7:0] >= st_q.wdata[15:8]
            || st_q.wdata[23:16] > st_q.wdata[15:8]) begin
          st_d.reject = 1'b1;
        end else if (st_q.wdata[7:0] < rca_pkg::PRE_MIN
                     || st_q.wdata[15:8] < rca_pkg::ALM_MIN) begin
          st_d.query = 1'b1;
        end else begin
          st_d.thr       = st_q.wdata[23:0];
          st_d.edit_open = 1'b0;
          st_d.query     = 1'b0;
        end
      end else if (st_q.awaddr == rca_pkg::OFF_QRY) begin
        if (st_q.query && st_q.wdata[0]) begin
          // accept: clamp to minimum and close the entry
          st_d.thr.pre = (st_q.pend.pre < rca_pkg::PRE_MIN)
                       ? rca_pkg::PRE_MIN : st_q.pend.pre;
          st_d.thr.alm = (st_q.pend.alm < rca_pkg::ALM_MIN)
                       ? rca_pkg::ALM_MIN : st_q.pend.alm;
          st_d.thr.ngt = (st_q.pend.ngt < rca_pkg::ALM_MIN)
                       ? rca_pkg::ALM_MIN : st_q.pend.ngt;
          st_d.query     = 1'b0;
          st_d.edit_open = 1'b0;
        end else if (st_q.query && st_q.wdata[1]) begin
          // decline: keep the low entry, edit stays open
          st_d.thr       = st_q.pend;
          st_d.query     = 1'b0;
          st_d.edit_open = 1'b1;
        end
      end else if (st_q.awaddr == rca_pkg::OFF_STAT) begin
        if (wmrg[22] && !(st_d.reject && !st_q.reject)) begin
          st_d.reject = 1'b0;
        end
      end else begin
        st_d.bresp = rca_pkg::RESP_ERR;
      end
    end

    // reads
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    ra = s_axi_araddr[7:0];
    if (s_axi_arvalid && s_axi_arready) begin
      st_d.rvalid = 1'b1;
      st_d.rresp  = rca_pkg::RESP_OK;
      st_d.rdata  = '0;
      if (ra == rca_pkg::OFF_CTRL) begin
        st_d.rdata[2:0] = {st_q.therm_en, st_q.style};
      end else if (ra == rca_pkg::OFF_DELAY) begin
        st_d.rdata[15:0] = st_q.delay;
      end else if (ra == rca_pkg::OFF_CUT) begin
        st_d.rdata[17:0] = {st_q.cyc_min, st_q.ini_min,
                            st_q.cyclical_cutoff_interval,
                            st_q.initial_cutoff_interval};
      end else if (ra == rca_pkg::OFF_THR) begin
        st_d.rdata[23:0] = st_q.thr;
      end else if (ra == rca_pkg::OFF_QRY) begin
        st_d.rdata[23:0] = st_q.pend;
      end else if (ra == rca_pkg::OFF_STAT) begin
        st_d.rdata[23:0] = {st_q.ngt, st_q.reject, st_q.edit_open,
                            st_q.query, st_q.cyc_out, st_q.released,
                            st_q.run, st_q.cd};
      end else begin
        st_d.rresp = rca_pkg::RESP_ERR;
      end
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q       <= '0;
      st_q.delay <= rca_pkg::DELAY_RST;
      st_q.thr   <= {rca_pkg::ALM_RST, rca_pkg::ALM_RST, rca_pkg::PRE_RST};
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  release_latch_a: assert property (
    st_q.released |=> st_q.released && !st_q.run)
    else $error("release dropped without reset");
  full_reload_a: assert property (
    st_q.run && st_q.style == rca_pkg::ABT_FULL && rise && st_q.cd != '0
    |=> st_q.cd == {1'b0, $past(st_q.delay)})
    else $error("full delay not reloaded");
  full_resume_a: assert property (
    st_q.run && st_q.style == rca_pkg::ABT_FULL && !st_q.abt && !rise
    && st_q.tick && st_q.cd > 17'h00001
    |=> st_q.cd == $past(st_q.cd) - 17'h00001)
    else $error("countdown did not resume");
  floor_hold_a: assert property (
    st_q.run && st_q.style == rca_pkg::ABT_FLOOR && st_q.abt
    && st_q.cd == rca_pkg::FLOOR_S |=> st_q.cd == rca_pkg::FLOOR_S)
    else $error("floor not held");
  floor_restore_a: assert property (
    st_q.run && st_q.style == rca_pkg::ABT_FLOOR && rise
    && st_q.cd < rca_pkg::FLOOR_S && st_q.cd != '0
    |=> st_q.cd == rca_pkg::FLOOR_S)
    else $error("floor not restored");
  extend_reload_a: assert property (
    st_q.run && st_q.style == rca_pkg::ABT_EXTEND && rise && st_q.cd != '0
    |=> st_q.cd == {1'b0, $past(st_q.delay)} + rca_pkg::EXTRA_S)
    else $error("extended delay not loaded");
  freeze_hold_a: assert property (
    st_q.run && st_q.style == rca_pkg::ABT_FREEZE && st_q.abt
    && st_q.cd != '0 |=> $stable(st_q.cd))
    else $error("frozen count moved");
  therm_first_a: assert property (
    st_q.th == rca_pkg::TH_IDLE && st_q.therm_en && |st_q.ht
    |=> st_q.cyc_out && st_q.tcnt == $past(ld_ini))
    else $error("first heat alarm ignored");
  therm_expire_a: assert property (
    st_q.th == rca_pkg::TH_INIT && t_exp |=> !st_q.cyc_out ##1
    (st_q.cyc_out == $past(|st_q.ht)))
    else $error("initial expiry wrong");
  therm_cyc_a: assert property (
    st_q.th == rca_pkg::TH_OFF && ht_new
    |=> st_q.th == rca_pkg::TH_CYC && st_q.cyc_out)
    else $error("cyclical run not started");
  thr_order_a: assert property (
    wr_fire && st_q.awaddr == rca_pkg::OFF_THR
    && st_q.wdata[7:0] >= st_q.wdata[15:8] |=> st_q.reject && $stable(st_q.thr))
    else $error("bad threshold accepted");
  bresp_hold_a: assert property (
    st_q.bvalid && !s_axi_bready |=> st_q.bvalid)
    else $error("write response dropped");

  release_c: cover property (st_q.run ##[1:300] st_q.released);
  floor_c: cover property (st_q.style == rca_pkg::ABT_FLOOR && rise);
  therm_c: cover property (st_q.th == rca_pkg::TH_SIL ##1 st_q.th == rca_pkg::TH_INIT);
  query_c: cover property (st_q.query ##[1:50] st_q.edit_open);
endmodule
`default_nettype wire

// ---- sim/rca_field.sv ----
// field side model: abort switch and heat detectors
`timescale 1ns/100ps
`default_nettype none
module rca_field (
  input  wire logic       aclk,
  input  wire logic       abort_cmd,
  input  wire logic [3:0] heat_cmd,
  output logic            abort_in,
  output logic [3:0]      heat_in
);
  // contacts change just after an edge, like a real switch seen by the sync flops
  always_ff @(posedge aclk) begin
    abort_in <= abort_cmd;
    heat_in  <= heat_cmd;
  end
endmodule
`default_nettype wire

// ---- sim/test_release_countdown_abort_cycling.sv ----
// self-checking bench of the release countdown block
`timescale 1ns/100ps
`default_nettype none
module test_release_countdown_abort_cycling;
  logic        aclk, aresetn, night_in, abt_cmd, abort_in;
  logic        release_out, cycle_out, countdown_run;
  logic [3:0]  heat_cmd, heat_in, wstrb;
  logic [7:0]  thr_act;
  logic [31:0] awaddr, wdata, araddr, rdata, rd;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp, resp;
  logic [16:0] r1;
  int          bad_count, n_checks, cyc;

  // ----------------------------------------
  // clock, parts and hang guard
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  rca_field i_fld (.aclk(aclk), .abort_cmd(abt_cmd), .heat_cmd(heat_cmd),
    .abort_in(abort_in), .heat_in(heat_in));
  rca_top #(.TICK_CYCLES(10)) i_dut (.aclk(aclk), .aresetn(aresetn), .abort_in(abort_in),
    .night_in(night_in), .heat_in(heat_in), .release_out(release_out),
    .cycle_out(cycle_out), .countdown_run(countdown_run), .alarm_thr_active(thr_act),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // whole run needs about 750 cycles; the ceiling leaves ample margin
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      bad_count = bad_count + 1;
      test_done();
    end
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic rst();
    @(posedge aclk);
    aresetn <= 1'b0;
    wt(2);
    aresetn <= 1'b1;
  endtask
  // requests stand until ready is seen high at a rising edge, then drop
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr  <= {24'h000000, a};
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bready <= 1'b0;
  endtask
  // read data taken at the edge where rvalid is seen high
  task automatic rdr(input logic [7:0] a);
    @(posedge aclk);
    araddr  <= {24'h000000, a};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic go(input logic [1:0] st, input logic [31:0] dl);
    rst();
    wr(rca_pkg::OFF_DELAY, dl);
    wr(rca_pkg::OFF_CTRL, {22'h000000, 2'h1, 6'h00, st});
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_defaults();
    rst();
    chk("thr active", 32'h14, {24'h0, thr_act});
    rdr(rca_pkg::OFF_DELAY);
    chk("delay", 32'h1e, rd);
    rdr(rca_pkg::OFF_THR);
    chk("thr", 32'h14140f, rd);
    rdr(8'h40);
    chk("unmapped resp", 32'h2, {30'h0, resp});
    $display("test defaults done");
  endtask
  task automatic t_full();
    go(rca_pkg::ABT_FULL, 32'h5);
    chk("run out", 32'h1, {31'h0, countdown_run});
    wt(10);
    abt_cmd <= 1'b1;
    wt(25);
    rdr(rca_pkg::OFF_STAT);
    chk("full reload", 32'h5, {15'h0, rd[16:0]});
    abt_cmd <= 1'b0;
    wt(20);
    rdr(rca_pkg::OFF_STAT);
    chk("run kept", 32'h1, {31'h0, rd[17] & ~rd[18]});
    chk("full resume", 32'h1, {31'h0, rd[16:0] < 5});
    abt_cmd <= 1'b1;
    wt(25);
    rdr(rca_pkg::OFF_STAT);
    chk("full rearm", 32'h5, {15'h0, rd[16:0]});
    abt_cmd <= 1'b0;
    wt(70);
    chk("released", 32'h1, {31'h0, release_out});
    chk("run ended", 32'h0, {31'h0, countdown_run});
    $display("test full done");
  endtask
  task automatic t_extend();
    go(rca_pkg::ABT_EXTEND, 32'h3);
    wt(10);
    abt_cmd <= 1'b1;
    wt(25);
    rdr(rca_pkg::OFF_STAT);
    chk("extend reload", 32'd93, {15'h0, rd[16:0]});
    abt_cmd <= 1'b0;
    wt(15);
    rdr(rca_pkg::OFF_STAT);
    chk("extend counts", 32'h1, {31'h0, rd[16:0] < 93 && rd[16:0] > 88});
    abt_cmd <= 1'b1;
    wt(10);
    rdr(rca_pkg::OFF_STAT);
    chk("extend rearm", 32'd93, {15'h0, rd[16:0]});
    abt_cmd <= 1'b0;
    $display("test extend done");
  endtask
  task automatic t_freeze();
    go(rca_pkg::ABT_FREEZE, 32'h9);
    wt(25);
    abt_cmd <= 1'b1;
    wt(15);
    rdr(rca_pkg::OFF_STAT);
    r1 = rd[16:0];
    wt(30);
    rdr(rca_pkg::OFF_STAT);
    chk("frozen", {15'h0, r1}, {15'h0, rd[16:0]});
    chk("no reload", 32'h1, {31'h0, r1 < 9 && r1 > 4});
    abt_cmd <= 1'b0;
    wt(25);
    rdr(rca_pkg::OFF_STAT);
    chk("resumed", 32'h1, {31'h0, rd[16:0] < r1});
    abt_cmd <= 1'b1;
    wt(10);
    rdr(rca_pkg::OFF_STAT);
    r1 = rd[16:0];
    wt(20);
    rdr(rca_pkg::OFF_STAT);
    chk("refrozen", {15'h0, r1}, {15'h0, rd[16:0]});
    abt_cmd <= 1'b0;
    $display("test freeze done");
  endtask
  task automatic t_floor();
    go(rca_pkg::ABT_FLOOR, 32'd13);
    wt(5);
    abt_cmd <= 1'b1;
    wt(60);
    rdr(rca_pkg::OFF_STAT);
    chk("floor hold", 32'd10, {15'h0, rd[16:0]});
    abt_cmd <= 1'b0;
    wt(25);
    rdr(rca_pkg::OFF_STAT);
    chk("floor resume", 32'h1, {31'h0, rd[16:0] < 10});
    abt_cmd <= 1'b1;
    wt(10);
    rdr(rca_pkg::OFF_STAT);
    chk("floor restore", 32'd10, {15'h0, rd[16:0]});
    abt_cmd <= 1'b0;
    $display("test floor done");
  endtask
  task automatic t_thr();
    rst();
    wr(rca_pkg::OFF_THR, 32'h00141414);
    rdr(rca_pkg::OFF_STAT);
    chk("reject", 32'h1, {31'h0, rd[22]});
    wr(rca_pkg::OFF_THR, 32'h0012180a);
    night_in <= 1'b1;
    wt(8);
    chk("night thr", 32'h12, {24'h0, thr_act});
    night_in <= 1'b0;
    wt(8);
    chk("day thr", 32'h18, {24'h0, thr_act});
    wr(rca_pkg::OFF_THR, 32'h00141405);
    rdr(rca_pkg::OFF_STAT);
    chk("query", 32'h1, {31'h0, rd[20]});
    wr(rca_pkg::OFF_QRY, 32'h1);
    rdr(rca_pkg::OFF_THR);
    chk("clamped pre", 32'h07, {24'h0, rd[7:0]});
    $display("test thresholds done");
  endtask
  task automatic t_therm();
    rst();
    wr(rca_pkg::OFF_CUT, 32'h000002ff);
    rdr(rca_pkg::OFF_CUT);
    chk("cut clamp", 32'hb4, {24'h0, rd[7:0]});
    wr(rca_pkg::OFF_CUT, 32'h00000203);
    wr(rca_pkg::OFF_CTRL, 32'h4);
    heat_cmd <= 4'h1;
    wt(10);
    chk("cycle on", 32'h1, {31'h0, cycle_out});
    wt(35);
    chk("rerun on", 32'h1, {31'h0, cycle_out});
    heat_cmd <= 4'h0;
    wt(55);
    chk("cycle off", 32'h0, {31'h0, cycle_out});
    heat_cmd <= 4'h2;
    wt(10);
    chk("recycle on", 32'h1, {31'h0, cycle_out});
    wt(35);
    chk("recycle off", 32'h0, {31'h0, cycle_out});
    $display("test thermal done");
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {aresetn, night_in, abt_cmd, heat_cmd} = '0;
    {awaddr, wdata, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hf;
    bad_count = 0;
    n_checks = 0;
    cyc = 0;
    t_defaults();
    t_full();
    t_extend();
    t_freeze();
    t_floor();
    t_thr();
    t_therm();
    test_done();
  end
endmodule
`default_nettype wire
